// >>> core/tmr_pkg.sv
package tmr_pkg;
  // register byte addresses on the bus
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_CNT_L = 8'h08;
  localparam logic [7:0] OFS_CNT_H = 8'h0C;
  localparam logic [7:0] OFS_CMPA_L = 8'h10;
  localparam logic [7:0] OFS_CMPA_H = 8'h14;
  localparam logic [7:0] OFS_CMPB_L = 8'h18;
  localparam logic [7:0] OFS_CMPB_H = 8'h1C;
  localparam logic [7:0] OFS_CAP_L = 8'h20;
  localparam logic [7:0] OFS_CAP_H = 8'h24;
  localparam logic [7:0] OFS_IRQ_EN = 8'h28;
  localparam logic [7:0] OFS_IRQ_FLAGS = 8'h2C;
  // mode_capture_clock_ctrl fields
  localparam int CB_FILT = 7;
  localparam int CB_EDGE = 6;
  localparam int CB_RSVD = 5;
  localparam int CB_WGM_HI = 3;
  localparam int CB_CS = 0;
  // lower mode / force control fields
  localparam int CA_ACMP = 4;
  localparam int CA_FORCE_A = 3;
  localparam int CA_FORCE_B = 2;
  localparam int CA_WGM_LO = 0;
  // enable and flag bit positions
  localparam int IB_CAP = 5;
  localparam int IB_CMPA = 4;
  localparam int IB_CMPB = 3;
  localparam int IB_OVF = 2;
  localparam logic [7:0] IRQ_MASK = 8'h3C;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
  // capture filter sample count
  localparam int FILT_DEPTH = 4;
  // clock select codes
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  // prescaler terminal masks
  localparam logic [9:0] PRE_M8 = 10'h007;
  localparam logic [9:0] PRE_M64 = 10'h03F;
  localparam logic [9:0] PRE_M256 = 10'h0FF;
  localparam logic [9:0] PRE_M1024 = 10'h3FF;
  // fixed top values
  localparam logic [15:0] TOP_MAX = 16'hFFFF;
  localparam logic [15:0] TOP_8 = 16'h00FF;
  localparam logic [15:0] TOP_9 = 16'h01FF;
  localparam logic [15:0] TOP_10 = 16'h03FF;
  // wave mode sets, one bit per 4-bit mode code
  localparam logic [15:0] WM_DUAL = 16'h0F0E;
  localparam logic [15:0] WM_CAP_TOP = 16'h5500;
  localparam logic [15:0] WM_CMPA_TOP = 16'h8A10;
  localparam logic [15:0] WM_NON_PWM = 16'h1011;
  localparam logic [15:0] WM_OVF_TOP = 16'hC0E0;
  localparam logic [15:0] WM_FIX8 = 16'h0022;
  localparam logic [15:0] WM_FIX9 = 16'h0044;
  localparam logic [15:0] WM_FIX10 = 16'h0088;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic {TMR_UP, TMR_DOWN} tmr_dir_t;
endpackage : tmr_pkg

// >>> core/tmr_core.sv
// Contract
// - with filter on, capture level changes only after four equal samples
// - filtered capture path lags the unfiltered one by four clocks
// - edge select zero captures falling edges, one captures rising edges
// - a capture copies the count into capture value and sets capture flag
// - when capture value is top, pin captures are ignored
// - reserved control bit 5 reads zero and is ignored; software writes zero
// - clock select 0..5: stopped, undivided, divide by 8, 64, 256, 1024
// - select 6 counts falling external edges, select 7 rising edges
// - external pin counts regardless of its own pin direction
// - counter bytes move atomically through one shared high-byte latch
// - a counter write blocks compare matches on the next timer tick
// - compare values are compared continuously; match drives flag and wave pin
// - compare writes commit both bytes together via the shared latch
// - capture value loads on pin or optional comparator event; may be top
// - capture value reads return a coherent pair via the shared latch
// - request issues only when enable, global enable and flag are all one
// - capture flag sets on capture, or at top when capture value is top
// - flags clear on vector acknowledge or on a written one; zero no effect
// - compare flags set on the tick after the counter matches
// - forced compare strobes never set compare flags
// - overflow flag sets on wrap in normal mode; in clear-on-match modes only when the count is FFFF
// - upper wave mode bits sit at bits 4:3 of the control register
// - 4-bit wave mode picks counting sequence, top source and waveform
`timescale 1ns/1ns
`default_nettype none
module tmr_core
  import tmr_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins and comparator
  input wire logic capture_pin,
  input wire logic ext_count_pin,
  input wire logic acmp_event,
  output logic compare_wave_pin_a,
  output logic compare_wave_pin_b,
  // cpu interrupt side
  input wire logic global_irq_en,
  input wire logic [3:0] vector_ack,
  output logic [3:0] irq_req
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0] ctrl_a_q, ctrl_b_q, irq_en_q, flags_q, temp_q;
  logic [15:0] count_q, cmp_a_q, cmp_b_q, cap_q;
  logic [9:0] pre_q;
  logic ext_q, ext_prev_q, block_q;
  logic [FILT_DEPTH-1:0] hist_q;
  logic filt_q, cap_lvl_prev_q;
  tmr_dir_t dir_q;
  logic bvalid_q, rvalid_q, awready_q, arready_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic wave_a_q, wave_b_q;
  logic [3:0] irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // bus handshakes: one write and one read in flight at most
  logic wr_go, rd_go;
  assign wr_go = awready_q;
  assign rd_go = arready_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
    end else begin
      awready_q <= s_axi_awvalid && s_axi_wvalid && !awready_q && !bvalid_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
    end else begin
      arready_q <= s_axi_arvalid && !arready_q && !rvalid_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write decode
  logic [7:0] wbyte;
  logic wb_en, wr_hit, wr_cnt, wr_cmpa, wr_cmpb, wr_ctrl_a, wr_ctrl_b;
  logic wr_temp, wr_en, wr_flags;
  assign wbyte = s_axi_wdata[7:0];
  assign wb_en = wr_go && s_axi_wstrb[0];

  always_comb begin
    wr_hit = 1'b1;
    wr_cnt = 1'b0;
    wr_cmpa = 1'b0;
    wr_cmpb = 1'b0;
    wr_ctrl_a = 1'b0;
    wr_ctrl_b = 1'b0;
    wr_temp = 1'b0;
    wr_en = 1'b0;
    wr_flags = 1'b0;
    if (s_axi_awaddr == OFS_CTRL_A) begin
      wr_ctrl_a = wb_en;
    end else if (s_axi_awaddr == OFS_CTRL_B) begin
      wr_ctrl_b = wb_en;
    end else if (s_axi_awaddr == OFS_CNT_L) begin
      wr_cnt = wb_en;
    end else if (s_axi_awaddr == OFS_CMPA_L) begin
      wr_cmpa = wb_en;
    end else if (s_axi_awaddr == OFS_CMPB_L) begin
      wr_cmpb = wb_en;
    end else if (s_axi_awaddr == OFS_CNT_H || s_axi_awaddr == OFS_CMPA_H ||
                 s_axi_awaddr == OFS_CMPB_H || s_axi_awaddr == OFS_CAP_H) begin
      wr_temp = wb_en;
    end else if (s_axi_awaddr == OFS_CAP_L) begin
      wr_hit = 1'b1; // capture value is read-only; write taken and dropped
    end else if (s_axi_awaddr == OFS_IRQ_EN) begin
      wr_en = wb_en;
    end else if (s_axi_awaddr == OFS_IRQ_FLAGS) begin
      wr_flags = wb_en;
    end else begin
      wr_hit = 1'b0;
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers; reserved bit dropped so it always reads zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_a_q <= CTRL_RST;
      ctrl_b_q <= CTRL_RST;
      irq_en_q <= CTRL_RST;
    end else begin
      if (wr_ctrl_a) begin
        ctrl_a_q <= wbyte & ~(8'h01 << CA_FORCE_A) & ~(8'h01 << CA_FORCE_B);
      end
      if (wr_ctrl_b) begin
        ctrl_b_q <= wbyte & ~(8'h01 << CB_RSVD);
      end
      if (wr_en) begin
        irq_en_q <= wbyte & IRQ_MASK;
      end
    end
  end

  // force strobes live only in the write cycle
  logic force_a, force_b;
  assign force_a = wr_ctrl_a && wbyte[CA_FORCE_A];
  assign force_b = wr_ctrl_a && wbyte[CA_FORCE_B];

  // mode decode: upper bits from bits 4:3, lower from the other control
  logic [3:0] wave_mode;
  logic [2:0] clock_select;
  logic capture_noise_filter_en, capture_edge_select;
  assign wave_mode = {ctrl_b_q[CB_WGM_HI+1:CB_WGM_HI], ctrl_a_q[CA_WGM_LO+1:CA_WGM_LO]};
  assign clock_select = ctrl_b_q[CB_CS+2:CB_CS];
  assign capture_noise_filter_en = ctrl_b_q[CB_FILT];
  assign capture_edge_select = ctrl_b_q[CB_EDGE];

  logic m_dual, m_cap_top, m_cmpa_top, m_non_pwm, m_ovf_top;
  assign m_dual = WM_DUAL[wave_mode];
  assign m_cap_top = WM_CAP_TOP[wave_mode];
  assign m_cmpa_top = WM_CMPA_TOP[wave_mode];
  assign m_non_pwm = WM_NON_PWM[wave_mode];
  assign m_ovf_top = WM_OVF_TOP[wave_mode];

  logic [15:0] top;
  always_comb begin
    top = TOP_MAX;
    if (WM_FIX8[wave_mode]) begin
      top = TOP_8;
    end else if (WM_FIX9[wave_mode]) begin
      top = TOP_9;
    end else if (WM_FIX10[wave_mode]) begin
      top = TOP_10;
    end else if (m_cap_top) begin
      top = cap_q;
    end else if (m_cmpa_top) begin
      top = cmp_a_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescaler and external pin sampling
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_q <= 10'h000;
      ext_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      pre_q <= pre_q + 10'h001;
      ext_q <= ext_count_pin;
      ext_prev_q <= ext_q;
    end
  end

  // timer tick selection; prescaler is free running, so the first
  // divided tick after a select change may come early
  logic tick;
  always_comb begin
    case (clock_select)
      CS_DIV1: tick = 1'b1;
      CS_DIV8: tick = (pre_q & PRE_M8) == PRE_M8;
      CS_DIV64: tick = (pre_q & PRE_M64) == PRE_M64;
      CS_DIV256: tick = (pre_q & PRE_M256) == PRE_M256;
      CS_DIV1024: tick = (pre_q & PRE_M1024) == PRE_M1024;
      CS_EXT_FALL: tick = ext_prev_q && !ext_q;
      CS_EXT_RISE: tick = !ext_prev_q && ext_q;
      default: tick = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter; a cpu write wins over the tick
  logic at_top, at_bot;
  assign at_top = count_q == top;
  assign at_bot = count_q == WORD_RST;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= WORD_RST;
      dir_q <= TMR_UP;
    end else if (wr_cnt) begin
      count_q <= {temp_q, wbyte};
    end else if (tick) begin
      if (m_dual) begin
        case (dir_q)
          TMR_UP: begin
            if (at_top) begin
              dir_q <= TMR_DOWN;
              count_q <= count_q - 16'h0001;
            end else begin
              count_q <= count_q + 16'h0001;
            end
          end
          default: begin
            if (at_bot) begin
              dir_q <= TMR_UP;
              count_q <= count_q + 16'h0001;
            end else begin
              count_q <= count_q - 16'h0001;
            end
          end
        endcase
      end else begin
        dir_q <= TMR_UP;
        count_q <= at_top ? WORD_RST : count_q + 16'h0001;
      end
    end
  end

  // counter write blocks the match on the next tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      block_q <= 1'b0;
    end else if (wr_cnt) begin
      block_q <= 1'b1;
    end else if (tick) begin
      block_q <= 1'b0;
    end
  end

  // compare values commit from the latch on the low-byte write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_a_q <= WORD_RST;
      cmp_b_q <= WORD_RST;
    end else begin
      if (wr_cmpa) begin
        cmp_a_q <= {temp_q, wbyte};
      end
      if (wr_cmpb) begin
        cmp_b_q <= {temp_q, wbyte};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture input: shift history, filtered level, edge detect
  logic cap_lvl, cap_edge, cap_evt;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hist_q <= '0;
      filt_q <= 1'b0;
    end else begin
      hist_q <= {hist_q[FILT_DEPTH-2:0], capture_pin};
      if (hist_q == {FILT_DEPTH{hist_q[0]}}) begin
        filt_q <= hist_q[0];
      end
    end
  end

  assign cap_lvl = capture_noise_filter_en ? filt_q : hist_q[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_lvl_prev_q <= 1'b0;
    end else begin
      cap_lvl_prev_q <= cap_lvl;
    end
  end

  assign cap_edge = capture_edge_select ? (cap_lvl && !cap_lvl_prev_q)
                                        : (!cap_lvl && cap_lvl_prev_q);
  // comparator source is optional; pin disconnected while capture is top
  assign cap_evt = !m_cap_top && (ctrl_a_q[CA_ACMP] ? acmp_event : cap_edge);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_q <= WORD_RST;
    end else if (cap_evt) begin
      cap_q <= count_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flag set terms; force strobes deliberately absent
  logic match_a, match_b, ovf_set;
  logic [7:0] set_v, clr_v;
  assign match_a = tick && !block_q && count_q == cmp_a_q;
  assign match_b = tick && !block_q && count_q == cmp_b_q;
  assign ovf_set = tick && (m_dual ? (dir_q == TMR_DOWN && at_bot)
                                   : m_ovf_top ? at_top : count_q == TOP_MAX);

  always_comb begin
    set_v = 8'h00;
    set_v[IB_CAP] = cap_evt || (m_cap_top && tick && at_top);
    set_v[IB_CMPA] = match_a;
    set_v[IB_CMPB] = match_b;
    set_v[IB_OVF] = ovf_set;
    clr_v = 8'h00;
    clr_v[IB_CAP] = vector_ack[3];
    clr_v[IB_CMPA] = vector_ack[2];
    clr_v[IB_CMPB] = vector_ack[1];
    clr_v[IB_OVF] = vector_ack[0];
    if (wr_flags) begin
      clr_v = clr_v | (wbyte & IRQ_MASK);
    end
  end

  // set beats clear so an event in the clearing cycle survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= CTRL_RST;
    end else begin
      flags_q <= (flags_q & ~clr_v) | set_v;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 4'h0;
    end else begin
      irq_q <= {flags_q[IB_CAP], flags_q[IB_CMPA], flags_q[IB_CMPB], flags_q[IB_OVF]} &
               {irq_en_q[IB_CAP], irq_en_q[IB_CMPA], irq_en_q[IB_CMPB], irq_en_q[IB_OVF]} &
               {4{global_irq_en}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wave pins: toggle in non-pwm modes, compare level otherwise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wave_a_q <= 1'b0;
      wave_b_q <= 1'b0;
    end else if (m_non_pwm) begin
      if (match_a || force_a) begin
        wave_a_q <= !wave_a_q;
      end
      if (match_b || force_b) begin
        wave_b_q <= !wave_b_q;
      end
    end else begin
      wave_a_q <= count_q < cmp_a_q;
      wave_b_q <= count_q < cmp_b_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path and shared high-byte latch
  logic [7:0] rbyte;
  logic rd_hit;
  always_comb begin
    rbyte = 8'h00;
    rd_hit = 1'b1;
    if (s_axi_araddr == OFS_CTRL_A) begin
      rbyte = ctrl_a_q;
    end else if (s_axi_araddr == OFS_CTRL_B) begin
      rbyte = ctrl_b_q;
    end else if (s_axi_araddr == OFS_CNT_L) begin
      rbyte = count_q[7:0];
    end else if (s_axi_araddr == OFS_CNT_H || s_axi_araddr == OFS_CAP_H) begin
      rbyte = temp_q;
    end else if (s_axi_araddr == OFS_CMPA_L) begin
      rbyte = cmp_a_q[7:0];
    end else if (s_axi_araddr == OFS_CMPA_H) begin
      rbyte = cmp_a_q[15:8];
    end else if (s_axi_araddr == OFS_CMPB_L) begin
      rbyte = cmp_b_q[7:0];
    end else if (s_axi_araddr == OFS_CMPB_H) begin
      rbyte = cmp_b_q[15:8];
    end else if (s_axi_araddr == OFS_CAP_L) begin
      rbyte = cap_q[7:0];
    end else if (s_axi_araddr == OFS_IRQ_EN) begin
      rbyte = irq_en_q;
    end else if (s_axi_araddr == OFS_IRQ_FLAGS) begin
      rbyte = flags_q;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // counter or capture low-byte read parks the high byte; a read on the same edge as a
  // high write wins, so software must not interleave the two
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      temp_q <= CTRL_RST;
    end else if (rd_go && s_axi_araddr == OFS_CNT_L) begin
      temp_q <= count_q[15:8];
    end else if (rd_go && s_axi_araddr == OFS_CAP_L) begin
      temp_q <= cap_q[15:8];
    end else if (wr_temp) begin
      temp_q <= wbyte;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rbyte};
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = awready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign compare_wave_pin_a = wave_a_q;
  assign compare_wave_pin_b = wave_b_q;
  assign irq_req = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_pin_rises;
    capture_noise_filter_en && capture_pin && !hist_q[0] && !filt_q;
  endsequence
  sequence s_pin_held;
    (capture_noise_filter_en && capture_pin) [*4];
  endsequence
  property p_filt_delay;
    @(posedge aclk) disable iff (!aresetn) s_pin_rises ##1 s_pin_held |=> filt_q;
  endproperty
  a_filt_delay: assert property (p_filt_delay) else $error("filter late");

  property p_filt_stable;
    @(posedge aclk) disable iff (!aresetn)
      $changed(filt_q) |-> $past(hist_q) == {FILT_DEPTH{$past(hist_q[0])}};
  endproperty
  a_filt_stable: assert property (p_filt_stable) else $error("filter changed early");

  property p_edge_dir;
    @(posedge aclk) disable iff (!aresetn)
      cap_edge |-> (cap_lvl == capture_edge_select) && (cap_lvl_prev_q != cap_lvl);
  endproperty
  a_edge_dir: assert property (p_edge_dir) else $error("wrong capture edge");

  property p_capture;
    @(posedge aclk) disable iff (!aresetn)
      cap_evt |=> cap_q == $past(count_q) && flags_q[IB_CAP];
  endproperty
  a_capture: assert property (p_capture) else $error("capture lost");

  property p_cap_top_hold;
    @(posedge aclk) disable iff (!aresetn) m_cap_top ##1 m_cap_top |-> $stable(cap_q);
  endproperty
  a_cap_top_hold: assert property (p_cap_top_hold) else $error("capture while top");

  property p_stopped;
    @(posedge aclk) disable iff (!aresetn)
      clock_select == CS_STOP && !wr_cnt |=> $stable(count_q);
  endproperty
  a_stopped: assert property (p_stopped) else $error("counter ran while stopped");

  property p_block;
    @(posedge aclk) disable iff (!aresetn)
      block_q && tick && !flags_q[IB_CMPA] && !vector_ack[2] |=> !flags_q[IB_CMPA];
  endproperty
  a_block: assert property (p_block) else $error("match not blocked");

  property p_match_flag;
    @(posedge aclk) disable iff (!aresetn)
      tick && !block_q && count_q == cmp_b_q |=> flags_q[IB_CMPB];
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("compare flag missing");

  property p_flag_clear;
    @(posedge aclk) disable iff (!aresetn)
      wr_flags && wbyte[IB_OVF] && !ovf_set |=> !flags_q[IB_OVF];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

  property p_irq_gate;
    @(posedge aclk) disable iff (!aresetn)
      irq_q[3] |-> $past(global_irq_en) && $past(irq_en_q[IB_CAP]) && $past(flags_q[IB_CAP]);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("ungated request");

endmodule : tmr_core
`default_nettype wire

// >>> tb/tmr_pins.sv
`timescale 1ns/1ns
`default_nettype none
module tmr_pins (
  // clock
  input wire logic aclk,
  // levels asked for by the bench
  input wire logic cap_req,
  input wire logic cnt_req,
  // pin levels seen by the timer
  output logic capture_pin = 1'b0,
  output logic ext_count_pin = 1'b0
);
  // pins move only after an edge, like a slow outside source
  always @(posedge aclk) begin
    capture_pin <= cap_req;
    ext_count_pin <= cnt_req;
  end
endmodule : tmr_pins
`default_nettype wire

// >>> tb/timer16_capture_compare_regs_bench.sv
`timescale 1ns/1ns
`default_nettype none
module timer16_capture_compare_regs_bench;
  import tmr_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, cap_req = 1'b0, cnt_req = 1'b0, cap_pin, cnt_pin;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [7:0] exp_q[$];
  logic [15:0] rnd;
  logic gie = 1'b1, wave_a, wave_b;
  logic [3:0] vack = 4'h0, irq;
  int err_count = 0, check_count = 0, seed = 98179;
  tmr_pins u_pins (.aclk(aclk), .cap_req(cap_req), .cnt_req(cnt_req),
    .capture_pin(cap_pin), .ext_count_pin(cnt_pin));
  tmr_core DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .capture_pin(cap_pin), .ext_count_pin(cnt_pin),
    .acmp_event(1'b0), .compare_wave_pin_a(wave_a), .compare_wave_pin_b(wave_b),
    .global_irq_en(gie), .vector_ack(vack), .irq_req(irq));
  initial begin
    forever #5 aclk = ~aclk;
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  // bounded wait on a sampled handshake; a hang ends the run
  task automatic hang(input int i);
    if (i >= 60) begin
      err_count++;
      finish_test();
    end
  endtask : hang
  // plain compare of a value sampled at an edge
  task automatic chk(input string n, input logic [3:0] e, input logic [3:0] g);
    check_count++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", n, e, g);
      err_count++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 60; i++) begin
      @(posedge aclk);
      if (awready === 1'b1) break;
    end
    hang(i);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    for (i = 0; i < 60; i++) begin
      @(posedge aclk);
      if (bvalid === 1'b1) break;
    end
    hang(i);
    chk("bresp", {2'b00, RESP_OKAY}, {2'b00, bresp});
    bready <= 1'b0;
  endtask : wr
  // expected byte is noted before the request goes out
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    int i;
    exp_q.push_back(e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 60; i++) begin
      @(posedge aclk);
      if (arready === 1'b1) break;
    end
    hang(i);
    arvalid <= 1'b0;
    for (i = 0; i < 60; i++) begin
      @(posedge aclk);
      if (rvalid === 1'b1) break;
    end
    hang(i);
    rready <= 1'b0;
  endtask : rd
  // watcher compares each read answer with the oldest note
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      check_count++;
      if (rdata !== {24'h000000, exp_q[0]}) begin
        $display("BAD rdata exp %h got %h", exp_q[0], rdata);
        err_count++;
      end
      void'(exp_q.pop_front());
      chk("rresp", {2'b00, (araddr > OFS_IRQ_FLAGS) ? RESP_SLVERR : RESP_OKAY},
          {2'b00, rresp});
    end
  end
  initial begin
    rnd = 16'($random(seed));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_CTRL_B, 8'h00);
    rd(OFS_IRQ_FLAGS, 8'h00);
    rd(8'h30, 8'h00);
    wr(OFS_CTRL_B, 8'hFF);
    rd(OFS_CTRL_B, 8'hDF);
    wr(OFS_CTRL_B, CTRL_RST);
    wr(OFS_CMPA_H, 8'h00);
    wr(OFS_CMPA_L, 8'h40);
    rd(OFS_CMPA_L, 8'h40);
    wr(OFS_CTRL_B, {5'h00, CS_DIV1});
    repeat (100) @(posedge aclk);
    wr(OFS_CTRL_B, CTRL_RST);
    // compare b is zero, so the first tick at count zero matches it too
    rd(OFS_IRQ_FLAGS, 8'h18);
    wr(OFS_IRQ_FLAGS, 8'h10);
    rd(OFS_IRQ_FLAGS, 8'h08);
    // both pins toggled once while counting; force toggles a only
    wr(OFS_CTRL_A, 8'h08);
    chk("wave_pins", 4'h1, {2'b00, wave_a, wave_b});
    wr(OFS_CNT_H, rnd[15:8]);
    wr(OFS_CNT_L, rnd[7:0]);
    wr(OFS_IRQ_EN, 8'h20);
    // filtered rising edge capture
    wr(OFS_CTRL_B, 8'hC0);
    cap_req <= 1'b1;
    repeat (10) @(posedge aclk);
    rd(OFS_CAP_L, rnd[7:0]);
    rd(OFS_CAP_H, rnd[15:8]);
    rd(OFS_IRQ_FLAGS, 8'h28);
    chk("irq_req", 4'h8, irq);
    gie <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("irq_req", 4'h0, irq);
    vack <= 4'h8;
    @(posedge aclk);
    vack <= 4'h0;
    rd(OFS_IRQ_FLAGS, 8'h08);
    wr(OFS_IRQ_FLAGS, 8'h3C);
    wr(OFS_CNT_H, 8'h00);
    wr(OFS_CNT_L, 8'h00);
    wr(OFS_CTRL_B, {5'h00, CS_EXT_RISE});
    repeat (5) begin
      repeat (4) @(posedge aclk);
      cnt_req <= 1'b1;
      repeat (4) @(posedge aclk);
      cnt_req <= 1'b0;
    end
    repeat (8) @(posedge aclk);
    wr(OFS_CTRL_B, CTRL_RST);
    rd(OFS_CNT_L, 8'h05);
    rd(OFS_CNT_H, 8'h00);
    // match at count zero fell on the blocked tick
    rd(OFS_IRQ_FLAGS, 8'h00);
    // unfiltered falling edge capture of the stopped count
    cap_req <= 1'b0;
    repeat (10) @(posedge aclk);
    rd(OFS_CAP_L, 8'h05);
    rd(OFS_IRQ_FLAGS, 8'h20);
    repeat (4) @(posedge aclk);
    finish_test();
  end
endmodule : timer16_capture_compare_regs_bench
`default_nettype wire
